// ===== shared/lbmc_pkg.sv
`default_nettype none
package lbmc_pkg;
	// Register addresses
	localparam logic [6:0] LBMC_ADDR_FUNC_CTRL = 7'h00;
	localparam logic [6:0] LBMC_ADDR_RANGE = 7'h01;
	localparam logic [6:0] LBMC_ADDR_LEVEL_CH1 = 7'h02;
	localparam logic [6:0] LBMC_ADDR_LEVEL_CH2 = 7'h03;
	localparam logic [6:0] LBMC_ADDR_HYST_CH1 = 7'h0B;
	localparam logic [6:0] LBMC_ADDR_HYST_CH2 = 7'h0C;
	localparam logic [6:0] LBMC_ADDR_UV_THRESH = 7'h0F;
	localparam logic [6:0] LBMC_ADDR_SUPPLY = 7'h38;
	localparam logic [6:0] LBMC_ADDR_STATUS = 7'h3F;
	// Field positions
	localparam int LBMC_FC_SPI_OK = 7;
	localparam int LBMC_FC_CLR_ERR = 6;
	localparam int LBMC_FC_DIM_EN2 = 2;
	localparam int LBMC_FC_DIM_EN1 = 1;
	localparam logic [7:0] LBMC_FC_WMASK = 8'h46;
	localparam logic [7:0] LBMC_RANGE_WMASK = 8'h03;
	localparam logic [7:0] LBMC_HYST_WMASK = 8'h03;
	localparam logic [7:0] LBMC_RESET_VAL = 8'h00;
	localparam int LBMC_FRAME_BITS = 16;

	typedef enum logic [1:0] {
		LBMC_OFF,
		LBMC_OPERATE,
		LBMC_UNDERVOLT,
		LBMC_FAILSILENT
	} lbmc_mode_t;

	// Per-channel analogue settings handed to the sense comparators
	typedef struct packed {
		logic range_select;
		logic [7:0] current_code;
		logic [1:0] hyst_setting;
	} lbmc_chan_cfg_t;
endpackage
`default_nettype wire

// ===== hdl/lbmc_top.sv
`default_nettype none
module lbmc_top
	import lbmc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Supply and device conditions (analogue comparators, asynchronous)
	input wire logic enable_pin,
	input wire logic supply_above_poff,
	input wire logic supply_above_pon,
	input wire logic [7:0] supply_voltage_code,
	input wire logic over_temp,
	input wire logic gate_fault,
	// Serial port
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic spi_mosi,
	output logic spi_miso,
	output logic spi_miso_oe,
	// Dimming inputs and current comparators per channel
	input wire logic dimming_input_ch1,
	input wire logic dimming_input_ch2,
	input wire logic [1:0] above_upper,
	input wire logic [1:0] below_lower,
	// Outputs
	output logic [1:0] gate_drive_out,
	output logic gate_supply_en,
	output logic supply_above_uv_flag,
	output lbmc_chan_cfg_t chan_cfg_ch1,
	output lbmc_chan_cfg_t chan_cfg_ch2,
	output lbmc_mode_t mode
);
	// How this block is put together
	// - Every pin level is asynchronous to clk, so all of them pass the same
	//   two-flop chain before any decision logic sees them.
	// - The supply code bus is synchronised bit by bit; it is a slow analogue
	//   reading that is assumed to settle long before it is used, so a
	//   torn sample lasts at most one cycle, though it can reach both the flag and the mode.
	// - The mode machine has four states. Power loss or a low enable wins
	//   over everything else, from any state.
	// - Operation is the only state that lets a gate switch. Undervoltage
	//   and fail-silent both hold the gates low.
	// - Undervoltage also drops the gate supply enable; fail-silent keeps it,
	//   so the serial port and gate supply stay alive for diagnosis.
	// - Fault sources are latched. A clear request only acts once the source
	//   has gone away; a fault that is still present wins over the clear.
	// - The serial port is sampled by clk, not clocked by the link clock.
	//   The link clock therefore needs half periods of several clk cycles,
	//   otherwise edges are missed and frames slip.
	// - A frame is sixteen bits, most significant first: write flag, seven
	//   address bits, eight data bits.
	// - Read data is chosen as soon as the address byte is complete and is
	//   shifted out during the data byte, one bit per falling link edge.
	// - Writes take effect one cycle after the last rising link edge of the
	//   frame; there is no staging register, so new settings apply at once.
	// - Reserved bits are masked on write, so they always read back as zero.
	// - The supply code address has no write path at all, which is why a
	//   write to it leaves no error behind.
	// - Off mode wipes every writable register. A user must reconfigure the
	//   channels after each pass through off mode.
	// - The hysteretic gate decision holds its level between the two
	//   comparator thresholds. The upper comparator wins if both are high,
	//   which keeps the transistor off in the unsafe case.
	// - Comparator thresholds themselves are analogue; this block only hands
	//   the range, level and hysteresis settings over in chan_cfg.
	// - Every top-level output is registered, so no glitch reaches a pin.
	// Limitations
	// - Pin to gate latency is about three clk cycles because of the
	//   synchronisers; the analogue loop must tolerate that delay.
	// - The chip select going high drops the bit counter, so a cut frame is
	//   simply forgotten and has no effect on any register.
	// - The chip select may stay low between frames; the counter wraps.
	// Trade-offs
	// - One wide synchroniser vector keeps the flop count obvious at the cost
	//   of a long bit map below; keep the map and the concatenation in step.
	// - Status is read only and shows mode and latched faults for software.

	// Two-flop synchronisers for every asynchronous input
	localparam int NS = 24;
	logic [NS-1:0] sync_a, sync_b;
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sync_a <= '0;
			sync_b <= '0;
		end else begin
			sync_a <= {enable_pin, supply_above_poff, supply_above_pon, supply_voltage_code,
				over_temp, gate_fault, spi_cs_n, spi_sclk, spi_mosi, dimming_input_ch1,
				dimming_input_ch2, above_upper, below_lower, 2'h0};
			sync_b <= sync_a;
		end
	end
	wire s_en = sync_b[23];
	wire s_poff = sync_b[22];
	wire s_pon = sync_b[21];
	wire [7:0] s_vcode = sync_b[20:13];
	wire s_ot = sync_b[12];
	wire s_gf = sync_b[11];
	wire s_cs_n = sync_b[10];
	wire s_sclk = sync_b[9];
	wire s_mosi = sync_b[8];
	wire [1:0] s_dim = {sync_b[6], sync_b[7]};
	wire [1:0] s_up = sync_b[5:4];
	wire [1:0] s_lo = sync_b[3:2];

	// Registers
	logic [7:0] func_ctrl, range_sel, level_ch1, level_ch2, hyst_ch1, hyst_ch2, uv_thresh;
	logic err_ot, err_gf, sclk_q;
	logic [4:0] bit_cnt;
	logic [15:0] shift_in;
	logic [7:0] shift_out;

	// Mode decisions
	wire power_bad = !s_poff || !s_en;
	wire power_ok = s_pon && s_en;
	wire uv_now = !(s_vcode > uv_thresh);
	wire any_err = err_ot || err_gf;
	wire in_off = (mode == LBMC_OFF);
	wire spi_live = !in_off && !s_cs_n; // Serial port dead in off mode
	wire sclk_rise = spi_live && s_sclk && !sclk_q;
	wire sclk_fall = spi_live && !s_sclk && sclk_q;
	wire frame_done = sclk_rise && (bit_cnt == 5'(LBMC_FRAME_BITS - 1));
	wire [15:0] frame = {shift_in[14:0], s_mosi};
	// Frame: bit15 write flag, bits14:8 address, bits7:0 data
	wire wr_stb = frame_done && frame[15];
	wire [6:0] wr_addr = frame[14:8];
	wire [7:0] wr_data = frame[7:0];
	wire clr_req = func_ctrl[LBMC_FC_CLR_ERR];
	wire clr_fire = clr_req && any_err && !(s_ot || s_gf);

	lbmc_mode_t next_mode;
	always_comb begin
		next_mode = mode;
		unique case (mode)
			LBMC_OFF: if (power_ok) next_mode = LBMC_OPERATE;
			LBMC_OPERATE: begin
				if (uv_now) next_mode = LBMC_UNDERVOLT;
				else if (s_ot || s_gf) next_mode = LBMC_FAILSILENT;
			end
			LBMC_UNDERVOLT: if (!uv_now) next_mode = LBMC_OPERATE;
			LBMC_FAILSILENT: if (clr_fire) next_mode = LBMC_OPERATE;
		endcase
		if (power_bad) next_mode = LBMC_OFF;
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) mode <= LBMC_OFF;
		else mode <= next_mode;
	end

	// Latched errors; a new fault wins over the clear
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			err_ot <= 1'b0;
			err_gf <= 1'b0;
		end else if (in_off) begin
			err_ot <= 1'b0;
			err_gf <= 1'b0;
		end else begin
			err_ot <= s_ot || (err_ot && !clr_fire);
			err_gf <= s_gf || (err_gf && !clr_fire);
		end
	end

	// Serial shifter: sample on rising, shift out on falling edge of the sampled clock
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			sclk_q <= 1'b0;
			bit_cnt <= '0;
			shift_in <= '0;
		end else begin
			sclk_q <= s_sclk;
			if (!spi_live) bit_cnt <= '0;
			else if (sclk_rise) begin
				shift_in <= frame;
				bit_cnt <= frame_done ? 5'h00 : bit_cnt + 5'h01;
			end
		end
	end

	// Read data selected once the address byte has arrived
	// The eighth bit is still in flight at that edge, so the address is
	// taken from the assembled frame rather than from the stored shifter.
	wire [6:0] rd_addr = frame[6:0];
	logic [7:0] rd_data;
	always_comb begin
		unique case (rd_addr)
			LBMC_ADDR_FUNC_CTRL: rd_data = func_ctrl | 8'(1 << LBMC_FC_SPI_OK);
			LBMC_ADDR_RANGE: rd_data = range_sel;
			LBMC_ADDR_LEVEL_CH1: rd_data = level_ch1;
			LBMC_ADDR_LEVEL_CH2: rd_data = level_ch2;
			LBMC_ADDR_HYST_CH1: rd_data = hyst_ch1;
			LBMC_ADDR_HYST_CH2: rd_data = hyst_ch2;
			LBMC_ADDR_UV_THRESH: rd_data = uv_thresh;
			LBMC_ADDR_SUPPLY: rd_data = s_vcode;
			LBMC_ADDR_STATUS: rd_data = {4'h0, err_gf, err_ot, 2'(mode)};
			default: rd_data = 8'h00;
		endcase
	end

	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			shift_out <= '0;
			spi_miso <= 1'b0;
			spi_miso_oe <= 1'b0;
		end else begin
			spi_miso_oe <= spi_live;
			if (!spi_live) shift_out <= '0;
			else if (sclk_rise && bit_cnt == 5'h07) shift_out <= rd_data;
			else if (sclk_fall && bit_cnt > 5'h08) shift_out <= {shift_out[6:0], 1'b0};
			spi_miso <= spi_live && shift_out[7];
		end
	end

	// Configuration writes; off mode wipes everything, writes apply at once
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			func_ctrl <= LBMC_RESET_VAL;
			range_sel <= LBMC_RESET_VAL;
			level_ch1 <= LBMC_RESET_VAL;
			level_ch2 <= LBMC_RESET_VAL;
			hyst_ch1 <= LBMC_RESET_VAL;
			hyst_ch2 <= LBMC_RESET_VAL;
			uv_thresh <= LBMC_RESET_VAL;
		end else if (in_off) begin
			func_ctrl <= LBMC_RESET_VAL;
			range_sel <= LBMC_RESET_VAL;
			level_ch1 <= LBMC_RESET_VAL;
			level_ch2 <= LBMC_RESET_VAL;
			hyst_ch1 <= LBMC_RESET_VAL;
			hyst_ch2 <= LBMC_RESET_VAL;
			uv_thresh <= LBMC_RESET_VAL;
		end else begin
			if (wr_stb && wr_addr == LBMC_ADDR_FUNC_CTRL)
				func_ctrl <= wr_data & LBMC_FC_WMASK;
			else if (clr_fire)
				func_ctrl[LBMC_FC_CLR_ERR] <= 1'b0; // Self-clearing
			if (wr_stb && wr_addr == LBMC_ADDR_RANGE) range_sel <= wr_data & LBMC_RANGE_WMASK;
			if (wr_stb && wr_addr == LBMC_ADDR_LEVEL_CH1) level_ch1 <= wr_data;
			if (wr_stb && wr_addr == LBMC_ADDR_LEVEL_CH2) level_ch2 <= wr_data;
			if (wr_stb && wr_addr == LBMC_ADDR_HYST_CH1) hyst_ch1 <= wr_data & LBMC_HYST_WMASK;
			if (wr_stb && wr_addr == LBMC_ADDR_HYST_CH2) hyst_ch2 <= wr_data & LBMC_HYST_WMASK;
			if (wr_stb && wr_addr == LBMC_ADDR_UV_THRESH) uv_thresh <= wr_data;
			// Supply code address has no write path and no error flag
		end
	end

	// Gate drive: hysteretic decision per channel
	// Order of tests matters: channel off first, then the upper threshold,
	// then the lower one; between thresholds the gate keeps its level.
	// Dropping the channel forces the gate low at the next clk edge, through the output register.
	wire run = (mode == LBMC_OPERATE);
	wire [1:0] dim_en = {func_ctrl[LBMC_FC_DIM_EN2], func_ctrl[LBMC_FC_DIM_EN1]};
	wire [1:0] ch_on = {2{run}} & dim_en & s_dim;
	logic [1:0] next_gate;
	always_comb begin
		for (int i = 0; i < 2; i++) begin
			next_gate[i] = gate_drive_out[i];
			if (!ch_on[i]) next_gate[i] = 1'b0;
			else if (s_up[i]) next_gate[i] = 1'b0;
			else if (s_lo[i]) next_gate[i] = 1'b1;
			else if (!gate_drive_out[i] && !s_up[i] && !s_lo[i]) next_gate[i] = gate_drive_out[i];
		end
	end

	// Registered outputs; comparator thresholds follow settings
	// Gate supply enable looks at the next mode so that it drops together
	// with the mode change instead of one cycle after it.
	// The settings bundle is copied every cycle, so a write reaches the
	// analogue side one cycle after the register changes.
	always_ff @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			gate_drive_out <= '0;
			gate_supply_en <= 1'b0;
			supply_above_uv_flag <= 1'b0;
			chan_cfg_ch1 <= '0;
			chan_cfg_ch2 <= '0;
		end else begin
			gate_drive_out <= next_gate;
			gate_supply_en <= (next_mode == LBMC_OPERATE) || (next_mode == LBMC_FAILSILENT);
			supply_above_uv_flag <= !uv_now;
			chan_cfg_ch1 <= '{range_sel[0], level_ch1, hyst_ch1[1:0]};
			chan_cfg_ch2 <= '{range_sel[1], level_ch2, hyst_ch2[1:0]};
		end
	end
endmodule
`default_nettype wire

// ===== dv/lbmc_chk.sv
`default_nettype none
module lbmc_chk
	import lbmc_pkg::*;
(
	// Clock and reset
	input wire logic clk,
	input wire logic sys_rst,
	// Device inputs
	input wire logic enable_pin,
	input wire logic supply_above_poff,
	input wire logic supply_above_pon,
	input wire logic over_temp,
	input wire logic gate_fault,
	input wire logic dimming_input_ch1,
	input wire logic dimming_input_ch2,
	input wire logic [1:0] above_upper,
	// Device outputs
	input wire logic [1:0] gate_drive_out,
	input wire logic gate_supply_en,
	input wire logic supply_above_uv_flag,
	input wire lbmc_mode_t mode
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (sys_rst);
	// Five-cycle windows allow two sync flops plus the output register
	AST_LOSS_FORCES_OFF: assert property (
		(!enable_pin || !supply_above_poff) [*5] |-> mode == LBMC_OFF) else $error("not off");
	AST_OFF_QUIET: assert property (
		mode == LBMC_OFF [*3] |-> gate_drive_out == 2'h0 && !gate_supply_en) else $error("off");
	AST_WAKE_CAUSE: assert property (
		$past(mode) == LBMC_OFF && mode != LBMC_OFF |-> mode == LBMC_OPERATE
		&& $past(enable_pin, 3) && $past(supply_above_pon, 3)) else $error("bad wake");
	// Flag drop in operation must be followed by undervoltage mode quickly
	AST_UV_ENTRY: assert property (
		$fell(supply_above_uv_flag) && $past(mode) == LBMC_OPERATE && mode != LBMC_OFF
		|-> ##[0:3] mode == LBMC_UNDERVOLT) else $error("no uv entry");
	AST_UV_QUIET: assert property (
		mode == LBMC_UNDERVOLT [*2] |-> gate_drive_out == 2'h0 && !gate_supply_en)
		else $error("uv outputs");
	AST_FAULT_STOPS: assert property (
		(over_temp || gate_fault) [*5] |-> mode != LBMC_OPERATE) else $error("fault ignored");
	AST_FS_QUIET: assert property (
		mode == LBMC_FAILSILENT [*2] |-> gate_drive_out == 2'h0) else $error("fs gate");
	AST_DIM1_LOW: assert property (
		!dimming_input_ch1 [*5] |-> !gate_drive_out[0]) else $error("gate1 on");
	AST_DIM2_LOW: assert property (
		!dimming_input_ch2 [*5] |-> !gate_drive_out[1]) else $error("gate2 on");
	AST_UPPER_OFF: assert property (
		above_upper[0] [*5] |-> !gate_drive_out[0]) else $error("gate1 over upper");
	// Main scenarios reached
	CVR_UV: cover property (mode == LBMC_UNDERVOLT);
	CVR_FS: cover property (mode == LBMC_FAILSILENT);
	CVR_GATE: cover property (gate_drive_out == 2'h1 && mode == LBMC_OPERATE);
endmodule
`default_nettype wire

// ===== dv/lbmc_spi_host.sv
`default_nettype none
module lbmc_spi_host (
	// Lines toward the device
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic spi_mosi,
	// Lines from the device
	input wire logic spi_miso,
	input wire logic spi_miso_oe
);
	timeunit 1ns;
	timeprecision 100ps;
	// Link clock rests low outside frames
	initial begin
		spi_cs_n = 1'h1;
		spi_sclk = 1'h0;
		spi_mosi = 1'h0;
	end
	// One frame, MSB first; a data bit read while undriven becomes unknown
	task automatic xfer(input logic wr, input logic [6:0] a, input logic [7:0] d,
		output logic [7:0] q);
		logic [15:0] f;
		f = {wr, a, d};
		q = 8'h00;
		spi_cs_n = 1'h0;
		for (int i = 15; i >= 0; i--) begin
			spi_mosi = f[i];
			#62.5 spi_sclk = 1'h1;
			if (i < 8) q[i] = spi_miso_oe ? spi_miso : 1'hx;
			#62.5 spi_sclk = 1'h0;
		end
		#62.5 spi_cs_n = 1'h1;
		spi_mosi = ~spi_mosi; // Stale level never looks valid
		#250;
	endtask
endmodule
`default_nettype wire

// ===== dv/lbmc_top_tb.sv
`default_nettype none
module lbmc_top_tb import lbmc_pkg::*; ;
	timeunit 1ns;
	timeprecision 100ps;
	typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e;} lbmc_row_t;
	logic clk = 1'h0, sys_rst = 1'h1, enable_pin = 1'h1, supply_above_poff = 1'h1;
	logic supply_above_pon = 1'h1, over_temp = 1'h0, gate_fault = 1'h0, dim1 = 1'h0;
	logic dim2 = 1'h0, spi_cs_n, spi_sclk, spi_mosi, spi_miso, spi_miso_oe;
	logic gate_supply_en, supply_above_uv_flag;
	logic [1:0] above_upper = 2'h0, below_lower = 2'h0, gate_drive_out;
	logic [7:0] supply_voltage_code = 8'h80, rd;
	lbmc_chan_cfg_t chan_cfg_ch1, chan_cfg_ch2;
	lbmc_mode_t mode;
	int fail_count = 0, n_compared = 0;
	// Register table: written value, expected readback
	lbmc_row_t rows [8] = '{
		'{7'h00, 8'h06, 8'h86}, // Serial ok bit reads as one
		'{7'h01, 8'hFF, 8'h03},
		'{7'h0B, 8'hFE, 8'h02}, // Hysteresis goes before level
		'{7'h0C, 8'h03, 8'h03},
		'{7'h02, 8'hA5, 8'hA5},
		'{7'h03, 8'h5A, 8'h5A},
		'{7'h0F, 8'h40, 8'h40},
		'{7'h38, 8'h11, 8'h80}};

	always #5 clk = ~clk;

	lbmc_top uut (.clk(clk), .sys_rst(sys_rst), .enable_pin(enable_pin),
		.supply_above_poff(supply_above_poff), .supply_above_pon(supply_above_pon),
		.supply_voltage_code(supply_voltage_code), .over_temp(over_temp),
		.gate_fault(gate_fault), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
		.spi_mosi(spi_mosi), .spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe),
		.dimming_input_ch1(dim1), .dimming_input_ch2(dim2), .above_upper(above_upper),
		.below_lower(below_lower), .gate_drive_out(gate_drive_out),
		.gate_supply_en(gate_supply_en), .supply_above_uv_flag(supply_above_uv_flag),
		.chan_cfg_ch1(chan_cfg_ch1), .chan_cfg_ch2(chan_cfg_ch2), .mode(mode));
	lbmc_spi_host host (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
		.spi_miso(spi_miso), .spi_miso_oe(spi_miso_oe));

	// Shared helpers: settle past the edge, compare, serial access, bounded mode wait
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic rdchk(input logic [6:0] a, input logic [7:0] e);
		host.xfer(1'h0, a, 8'h00, rd);
		check(16'(rd), 16'(e));
	endtask
	task automatic expect_mode(input lbmc_mode_t m);
		int i;
		for (i = 0; i < 40 && mode !== m; i++) step(1);
		check(16'(mode), 16'(m));
		if (mode !== m) complete_run();
	endtask
	task automatic complete_run();
		$display("compared %0d, mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask

	// Main sequence
	initial begin
		step(8);
		sys_rst = 1'h0;
		expect_mode(LBMC_OPERATE);
		foreach (rows[r]) begin
			host.xfer(1'h1, rows[r].a, rows[r].d, rd);
			rdchk(rows[r].a, rows[r].e);
		end
		check(16'(chan_cfg_ch1), 16'({1'h1, 8'hA5, 2'h2}));
		check(16'(chan_cfg_ch2), 16'({1'h1, 8'h5A, 2'h3}));
		$display("register table done");
		step(1);
		dim1 = 1'h1; // Raised only once both channels are configured
		dim2 = 1'h1;
		below_lower = 2'h3;
		step(6);
		check(16'(gate_drive_out), 16'h0003);
		below_lower = 2'h0;
		step(6);
		check(16'(gate_drive_out), 16'h0003);
		above_upper = 2'h1;
		step(6);
		check(16'(gate_drive_out), 16'h0002);
		above_upper = 2'h0;
		below_lower = 2'h3;
		host.xfer(1'h1, LBMC_ADDR_FUNC_CTRL, 8'h02, rd);
		host.xfer(1'h1, LBMC_ADDR_LEVEL_CH1, 8'h10, rd);
		check(16'(chan_cfg_ch1.current_code), 16'h0010);
		check(16'(gate_drive_out), 16'h0001);
		$display("gate control done");
		step(1);
		supply_voltage_code = 8'h40;
		expect_mode(LBMC_UNDERVOLT);
		step(2);
		check(16'({supply_above_uv_flag, gate_supply_en, gate_drive_out}), 16'h0000);
		supply_voltage_code = 8'h41;
		expect_mode(LBMC_OPERATE);
		step(4);
		check(16'({supply_above_uv_flag, gate_drive_out}), 16'h0005);
		$display("undervoltage done");
		for (int k = 0; k < 2; k++) begin
			{gate_fault, over_temp} = 2'(k + 1);
			expect_mode(LBMC_FAILSILENT);
			step(2);
			check(16'({gate_supply_en, gate_drive_out}), 16'h0004);
			rdchk(LBMC_ADDR_LEVEL_CH1, 8'h10);
			step(1);
			{gate_fault, over_temp} = 2'h0;
			host.xfer(1'h1, LBMC_ADDR_FUNC_CTRL, 8'h42, rd);
			expect_mode(LBMC_OPERATE);
			rdchk(LBMC_ADDR_FUNC_CTRL, 8'h82);
			$display("fault %0d done", k);
		end
		dim1 = 1'h0; // Channels dropped before switching off
		dim2 = 1'h0;
		step(6);
		check(16'(gate_drive_out), 16'h0000);
		enable_pin = 1'h0;
		expect_mode(LBMC_OFF);
		step(3);
		check(16'({gate_supply_en, gate_drive_out, spi_miso_oe}), 16'h0000);
		supply_above_pon = 1'h0;
		enable_pin = 1'h1;
		step(20);
		check(16'(mode), 16'(LBMC_OFF));
		supply_above_pon = 1'h1;
		expect_mode(LBMC_OPERATE);
		rdchk(LBMC_ADDR_LEVEL_CH1, 8'h00);
		step(1);
		supply_above_poff = 1'h0;
		expect_mode(LBMC_OFF);
		$display("off mode done");
		complete_run();
	end
endmodule

bind lbmc_top lbmc_chk chk (.clk(clk), .sys_rst(sys_rst), .enable_pin(enable_pin),
	.supply_above_poff(supply_above_poff), .supply_above_pon(supply_above_pon),
	.over_temp(over_temp), .gate_fault(gate_fault), .dimming_input_ch1(dimming_input_ch1),
	.dimming_input_ch2(dimming_input_ch2), .above_upper(above_upper),
	.gate_drive_out(gate_drive_out), .gate_supply_en(gate_supply_en),
	.supply_above_uv_flag(supply_above_uv_flag), .mode(mode));
`default_nettype wire
